// file: design/wkrm_defs.vh
// register indices, field layouts, reset values and event bits of the wake routing masks
`ifndef WKRM_DEFS_VH
`define WKRM_DEFS_VH

// register indices; byte address on the bus is four times the index
`define WKRM_IDX_DET_MAIN_GP 6'h18
`define WKRM_IDX_DET_STBY_FIXED 6'h19
`define WKRM_IDX_DET_STBY_GP 6'h1A
`define WKRM_IDX_PB_FIXED 6'h1B
`define WKRM_IDX_EVT_STATUS 6'h1C
`define WKRM_IDX_EVT_MASK 6'h1D
`define WKRM_IDX_CONTROL 6'h1E

// reset values
`define WKRM_RST_DET_MAIN_GP 8'hFF
`define WKRM_RST_DET_STBY_FIXED 5'h1F
`define WKRM_RST_DET_STBY_GP 8'hFF
`define WKRM_RST_PB_FIXED 5'h00
`define WKRM_RST_EVT_MASK 4'h0

// fixed source bit positions
`define WKRM_FIX_RING1 0
`define WKRM_FIX_RING2 1
`define WKRM_FIX_KEYBOARD 2
`define WKRM_FIX_MOUSE 3
`define WKRM_FIX_INFRARED 4
`define WKRM_FIX_WIDTH 5
`define WKRM_GP_WIDTH 8
// general input that also carries ring indicate
`define WKRM_GP_RING_SHARED 4

// event status and mask layout
`define WKRM_EVT_DET_GP 0
`define WKRM_EVT_DET_FIXED 1
`define WKRM_EVT_PB 2
`define WKRM_EVT_POWER_CHANGE 3
`define WKRM_EVT_WIDTH 4

// control register: soft reset of the four routing masks, not the event mask, self clearing
`define WKRM_CTRL_SOFT_RESET 0

`endif

// file: design/wkrm_wake_event_routing_masks.v
// wake event routing masks: four enable masks gating raw wake sources, on classic Wishbone
//
// Design decision made here: register access over Wishbone.
`timescale 1ns/1ns
`include "wkrm_defs.vh"

module wkrm_wake_event_routing_masks (
   input wire ref_clk,
   input wire resetn,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [7:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   output wire [31:0] wb_dat_o,
   output wire wb_ack_o,
   input wire mainPowerPresent,
   input wire [7:0] generalWakeInput,
   input wire consumerInfraredSource,
   input wire mouseSource,
   input wire keyboardSource,
   input wire firstSerialRingIndicator,
   input wire secondSerialRingIndicator,
   input wire [4:0] mainPowerFixedGate,
   output wire [7:0] detectorGeneralWake,
   output wire [4:0] detectorFixedWake,
   output wire [4:0] powerButtonFixedWake,
   output wire irq
);

   reg [7:0] detMainGp_ff;
   reg [4:0] detStbyFixed_ff;
   reg [7:0] detStbyGp_ff;
   reg [4:0] pbFixed_ff;
   reg [3:0] evtStatus_ff;
   reg [3:0] evtMask_ff;
   reg ack_ff;
   reg [31:0] rdData_ff;
   reg irq_ff;
   reg [7:0] detGp_ff;
   reg [4:0] detFixed_ff;
   reg [4:0] pbOut_ff;
   reg powerPrev_ff;

   reg [7:0] nxt_detMainGp;
   reg [4:0] nxt_detStbyFixed;
   reg [7:0] nxt_detStbyGp;
   reg [4:0] nxt_pbFixed;
   reg [3:0] nxt_evtStatus;
   reg [3:0] nxt_evtMask;
   reg [31:0] nxt_rdData;
   reg [7:0] nxt_detGp;
   reg [4:0] nxt_detFixed;
   reg [4:0] nxt_pbOut;
   reg [3:0] evtSet;

   wire [5:0] regIdx;
   wire access;
   wire wrLane0;
   wire rdAccess;
   wire powerSync;
   wire [7:0] gpSync;
   wire [4:0] fixedSync;

   assign regIdx = wb_adr_i[7:2];
   // one access per request: the ack cycle is never taken again
   assign access = wb_cyc_i & wb_stb_i & ~ack_ff;
   assign wrLane0 = access & wb_we_i & wb_sel_i[0];
   assign rdAccess = access & ~wb_we_i;

   assign wb_dat_o = rdData_ff;
   assign wb_ack_o = ack_ff;
   assign irq = irq_ff;
   assign detectorGeneralWake = detGp_ff;
   assign detectorFixedWake = detFixed_ff;
   assign powerButtonFixedWake = pbOut_ff;

   // raw sources are asynchronous levels; each passes two flops before the gates
   wkrm_sync2 #(
      .WIDTH(1)
   ) wkrm_sync2_power_inst (
      .ref_clk(ref_clk),
      .resetn(resetn),
      .asyncIn(mainPowerPresent),
      .syncOut(powerSync)
   );

   wkrm_sync2 #(
      .WIDTH(8)
   ) wkrm_sync2_general_inst (
      .ref_clk(ref_clk),
      .resetn(resetn),
      .asyncIn(generalWakeInput),
      .syncOut(gpSync)
   );

   wkrm_sync2 #(
      .WIDTH(5)
   ) wkrm_sync2_fixed_inst (
      .ref_clk(ref_clk),
      .resetn(resetn),
      .asyncIn({consumerInfraredSource, mouseSource, keyboardSource,
                secondSerialRingIndicator, firstSerialRingIndicator}),
      .syncOut(fixedSync)
   );

   // register file: writes, soft reset, read mux
   always @* begin
      nxt_detMainGp = detMainGp_ff;
      nxt_detStbyFixed = detStbyFixed_ff;
      nxt_detStbyGp = detStbyGp_ff;
      nxt_pbFixed = pbFixed_ff;
      nxt_evtMask = evtMask_ff;
      nxt_rdData = rdData_ff;
      if (wrLane0) begin
         case (regIdx)
            `WKRM_IDX_DET_MAIN_GP: begin
               nxt_detMainGp = wb_dat_i[7:0];
            end
            `WKRM_IDX_DET_STBY_FIXED: begin
               nxt_detStbyFixed = wb_dat_i[4:0];
            end
            `WKRM_IDX_DET_STBY_GP: begin
               nxt_detStbyGp = wb_dat_i[7:0];
            end
            `WKRM_IDX_PB_FIXED: begin
               nxt_pbFixed = wb_dat_i[4:0];
            end
            `WKRM_IDX_EVT_MASK: begin
               nxt_evtMask = wb_dat_i[3:0];
            end
            `WKRM_IDX_CONTROL: begin
               if (wb_dat_i[`WKRM_CTRL_SOFT_RESET]) begin
                  nxt_detMainGp = `WKRM_RST_DET_MAIN_GP;
                  nxt_detStbyFixed = `WKRM_RST_DET_STBY_FIXED;
                  nxt_detStbyGp = `WKRM_RST_DET_STBY_GP;
                  nxt_pbFixed = `WKRM_RST_PB_FIXED;
               end
            end
            default: begin
               nxt_evtMask = evtMask_ff;
            end
         endcase
      end
      if (rdAccess) begin
         case (regIdx)
            `WKRM_IDX_DET_MAIN_GP: begin
               nxt_rdData = {24'h000000, detMainGp_ff};
            end
            `WKRM_IDX_DET_STBY_FIXED: begin
               nxt_rdData = {27'h0000000, detStbyFixed_ff};
            end
            `WKRM_IDX_DET_STBY_GP: begin
               nxt_rdData = {24'h000000, detStbyGp_ff};
            end
            `WKRM_IDX_PB_FIXED: begin
               nxt_rdData = {27'h0000000, pbFixed_ff};
            end
            `WKRM_IDX_EVT_STATUS: begin
               nxt_rdData = {28'h0000000, evtStatus_ff};
            end
            `WKRM_IDX_EVT_MASK: begin
               nxt_rdData = {28'h0000000, evtMask_ff};
            end
            default: begin
               // unmapped and control read as zero, still acknowledged
               nxt_rdData = 32'h00000000;
            end
         endcase
      end
   end

   // routing gates use the stored masks, except the main-power fixed gate taken from mainPowerFixedGate, so a write shows one cycle later
   always @* begin
      if (powerSync) begin
         nxt_detGp = gpSync & detMainGp_ff;
         nxt_detFixed = fixedSync & mainPowerFixedGate;
      end else begin
         nxt_detGp = gpSync & detStbyGp_ff;
         nxt_detFixed = fixedSync & detStbyFixed_ff;
      end
      nxt_pbOut = fixedSync & pbFixed_ff;
   end

   // sticky events; a read of status clears, but a new event wins
   always @* begin
      evtSet = 4'h0;
      evtSet[`WKRM_EVT_DET_GP] = |(nxt_detGp & ~detGp_ff);
      evtSet[`WKRM_EVT_DET_FIXED] = |(nxt_detFixed & ~detFixed_ff);
      evtSet[`WKRM_EVT_PB] = |(nxt_pbOut & ~pbOut_ff);
      evtSet[`WKRM_EVT_POWER_CHANGE] = powerSync ^ powerPrev_ff;
      nxt_evtStatus = evtStatus_ff;
      if (rdAccess && regIdx == `WKRM_IDX_EVT_STATUS) begin
         nxt_evtStatus = 4'h0;
      end
      nxt_evtStatus = nxt_evtStatus | evtSet;
   end

   // mask registers: one process each, reset to their defaults
   always @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         detMainGp_ff <= `WKRM_RST_DET_MAIN_GP;
      end else begin
         detMainGp_ff <= nxt_detMainGp;
      end
   end

   always @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         detStbyFixed_ff <= `WKRM_RST_DET_STBY_FIXED;
      end else begin
         detStbyFixed_ff <= nxt_detStbyFixed;
      end
   end

   always @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         detStbyGp_ff <= `WKRM_RST_DET_STBY_GP;
      end else begin
         detStbyGp_ff <= nxt_detStbyGp;
      end
   end

   always @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         pbFixed_ff <= `WKRM_RST_PB_FIXED;
      end else begin
         pbFixed_ff <= nxt_pbFixed;
      end
   end

   // event status and its mask
   always @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         evtStatus_ff <= 4'h0;
      end else begin
         evtStatus_ff <= nxt_evtStatus;
      end
   end

   always @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         evtMask_ff <= `WKRM_RST_EVT_MASK;
      end else begin
         evtMask_ff <= nxt_evtMask;
      end
   end

   // bus answer: ack one cycle after the taking edge, data with it
   always @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         ack_ff <= 1'b0;
      end else begin
         ack_ff <= access;
      end
   end

   always @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         rdData_ff <= 32'h00000000;
      end else begin
         rdData_ff <= nxt_rdData;
      end
   end

   // built from next values so the level tracks status without an extra cycle
   always @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         irq_ff <= 1'b0;
      end else begin
         irq_ff <= |(nxt_evtStatus & nxt_evtMask);
      end
   end

   // gated outputs, registered so each leaves the block from a flop
   always @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         detGp_ff <= 8'h00;
      end else begin
         detGp_ff <= nxt_detGp;
      end
   end

   always @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         detFixed_ff <= 5'h00;
      end else begin
         detFixed_ff <= nxt_detFixed;
      end
   end

   always @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         pbOut_ff <= 5'h00;
      end else begin
         pbOut_ff <= nxt_pbOut;
      end
   end

   always @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         powerPrev_ff <= 1'b0;
      end else begin
         powerPrev_ff <= powerSync;
      end
   end

endmodule // wkrm_wake_event_routing_masks

// two-flop synchroniser for asynchronous levels
module wkrm_sync2 #(
   parameter WIDTH = 1
) (
   input wire ref_clk,
   input wire resetn,
   input wire [WIDTH-1:0] asyncIn,
   output wire [WIDTH-1:0] syncOut
);

   // only the second stage leaves this module; the first may be metastable
   reg [WIDTH-1:0] stageA_ff;
   reg [WIDTH-1:0] stageB_ff;

   assign syncOut = stageB_ff;

   always @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         stageA_ff <= {WIDTH{1'b0}};
         stageB_ff <= {WIDTH{1'b0}};
      end else begin
         stageA_ff <= asyncIn;
         stageB_ff <= stageA_ff;
      end
   end

endmodule // wkrm_sync2

// file: bench/wkrm_checker.sv
// port assertions for the wake routing masks
`timescale 1ns/1ns
module wkrm_checker (
   input logic ref_clk,
   input logic resetn,
   input logic wb_cyc_i,
   input logic wb_stb_i,
   input logic wb_we_i,
   input logic [7:0] wb_adr_i,
   input logic [31:0] wb_dat_o,
   input logic wb_ack_o,
   input logic [7:0] generalWakeInput,
   input logic keyboardSource,
   input logic [7:0] detectorGeneralWake,
   input logic [4:0] detectorFixedWake,
   input logic [4:0] powerButtonFixedWake,
   input logic irq
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   sequence reqTaken;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence rsvdRead;
      wb_ack_o && !wb_we_i && (wb_adr_i[7:2] == 6'h19 || wb_adr_i[7:2] == 6'h1B);
   endsequence
   ack_after_req_a: assert property (reqTaken |=> wb_ack_o) else $error("no ack");
   ack_single_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("long ack");
   ack_idle_a: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o) else $error("stray ack");
   rsvd_zero_a: assert property (rsvdRead |-> wb_dat_o[7:5] == 3'h0) else $error("rsvd set");
   // a general output bit, or the keyboard bit of a fixed output, can only be high where its raw source was high three edges back
   gp_gate_a: assert property ((detectorGeneralWake & ~$past(generalWakeInput, 3)) == 8'h00)
      else $error("gp leak");
   fix_gate_a: assert property (detectorFixedWake[2] |-> $past(keyboardSource, 3))
      else $error("fix leak");
   pb_gate_a: assert property (powerButtonFixedWake[2] |-> $past(keyboardSource, 3))
      else $error("pb leak");
   reset_out_a: assert property ($rose(resetn) |-> powerButtonFixedWake == 5'h00 && !irq)
      else $error("reset out");
endmodule // wkrm_checker
bind wkrm_wake_event_routing_masks wkrm_checker wkrm_checker_inst (.ref_clk, .resetn,
   .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .generalWakeInput,
   .keyboardSource, .detectorGeneralWake, .detectorFixedWake, .powerButtonFixedWake, .irq);

// file: bench/wkrm_far_model.sv
// power button generator model: counts wake pulses reaching it
`timescale 1ns/1ns
module wkrm_far_model (
   input logic ref_clk,
   input logic resetn,
   input logic [4:0] powerButtonFixedWake,
   output logic [7:0] pbPulses
);
   logic [4:0] prevPb_ff;
   always @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         prevPb_ff <= 5'h00;
         pbPulses <= 8'h00;
      end else begin
         prevPb_ff <= powerButtonFixedWake;
         // one pulse per idle-to-active change, as the generator sees it
         if (|powerButtonFixedWake && !(|prevPb_ff)) pbPulses <= pbPulses + 8'h01;
      end
   end
endmodule // wkrm_far_model

// file: bench/tb_wake_event_routing_masks.sv
// self-checking bench for the wake routing masks
`timescale 1ns/1ns
module tb_wake_event_routing_masks;
   logic ref_clk = 1'b0, resetn = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
   logic mainPowerPresent = 1'b0, wb_ack_o, irq;
   logic [3:0] wb_sel_i = 4'h0;
   logic [4:0] fix = 5'h00, mainPowerFixedGate = 5'h00, detectorFixedWake, powerButtonFixedWake;
   logic [7:0] wb_adr_i = 8'h00, generalWakeInput = 8'h00, detectorGeneralWake, pbPulses;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
   int n_fail = 0, comparisons = 0;
   wkrm_wake_event_routing_masks wkrm_wake_event_routing_masks_inst (.ref_clk(ref_clk),
      .resetn(resetn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
      .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .mainPowerPresent(mainPowerPresent),
      .generalWakeInput(generalWakeInput), .mainPowerFixedGate(mainPowerFixedGate),
      .detectorGeneralWake(detectorGeneralWake), .detectorFixedWake(detectorFixedWake),
      .powerButtonFixedWake(powerButtonFixedWake), .irq(irq),
      .consumerInfraredSource(fix[4]), .mouseSource(fix[3]), .keyboardSource(fix[2]),
      .secondSerialRingIndicator(fix[1]), .firstSerialRingIndicator(fix[0]));
   wkrm_far_model wkrm_far_model_inst (.ref_clk(ref_clk), .resetn(resetn),
      .powerButtonFixedWake(powerButtonFixedWake), .pbPulses(pbPulses));
   initial forever #25 ref_clk = ~ref_clk;
   task automatic xfer(input [5:0] i, input w, input [3:0] s, input [7:0] d);
      int n;
      n = 0;
      @(posedge ref_clk);
      wb_cyc_i <= 1'h1;
      wb_stb_i <= 1'h1;
      wb_we_i <= w;
      wb_sel_i <= s;
      wb_adr_i <= {i, 2'h0};
      wb_dat_i <= {24'h0, d};
      do begin
         @(posedge ref_clk);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 50);
      q = wb_dat_o;
      wb_cyc_i <= 1'h0;
      wb_stb_i <= 1'h0;
      if (n >= 50) n_fail++;
   endtask
   task automatic wr(input [5:0] i, input [7:0] d);
      xfer(i, 1'h1, 4'h1, d);
   endtask
   task automatic rd(input [5:0] i);
      xfer(i, 1'h0, 4'h1, 8'h00);
   endtask
   task automatic chk(input string nm, input [31:0] e, input [31:0] g);
      comparisons++;
      if (g !== e) begin
         $display("wrong value %s expected %h seen %h", nm, e, g);
         n_fail++;
      end
   endtask
   task automatic settle();
      repeat (5) @(posedge ref_clk);
   endtask
   task automatic wrap_up();
      $display("comparisons %0d n_fail %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic regDefaults();
      logic [7:0] e [4] = '{8'hFF, 8'h1F, 8'hFF, 8'h00};
      for (int i = 0; i < 4; i++) begin
         rd(6'h18 + 6'(i));
         chk("default", {24'h0, e[i]}, q);
      end
      rd(6'h3F);
      chk("unmapped", 32'h0, q);
   endtask
   task automatic regAccess();
      wr(6'h18, 8'h5A);
      rd(6'h18);
      chk("mainGp", 32'h5A, q);
      wr(6'h19, 8'hFF);
      rd(6'h19);
      chk("stbyFix", 32'h1F, q);
      wr(6'h1B, 8'hE7);
      // lane 0 disabled: the write must be dropped
      xfer(6'h1B, 1'h1, 4'h0, 8'hFF);
      rd(6'h1B);
      chk("pbMask", 32'h07, q);
   endtask
   task automatic routes();
      mainPowerPresent <= 1'h1;
      generalWakeInput <= 8'hFF;
      fix <= 5'h1F;
      mainPowerFixedGate <= 5'h15;
      settle();
      chk("mainGp", 32'h5A, detectorGeneralWake);
      chk("mainFix", 32'h15, detectorFixedWake);
      chk("pbFix", 32'h07, powerButtonFixedWake);
      wr(6'h1A, 8'h3C);
      wr(6'h19, 8'h0A);
      mainPowerPresent <= 1'h0;
      settle();
      chk("stbyGp", 32'h3C, detectorGeneralWake);
      chk("stbyFix", 32'h0A, detectorFixedWake);
   endtask
   task automatic softReset();
      wr(6'h1E, 8'h01);
      rd(6'h18);
      chk("mainGp", 32'hFF, q);
      settle();
      chk("stbyGp", 32'hFF, detectorGeneralWake);
      chk("pbFix", 32'h00, powerButtonFixedWake);
   endtask
   task automatic irqFlow();
      wr(6'h1D, 8'h04);
      rd(6'h1C);
      settle();
      chk("irqIdle", 32'h0, irq);
      wr(6'h1B, 8'h04);
      settle();
      chk("irqSet", 32'h1, irq);
      rd(6'h1C);
      chk("status", 32'h4, q & 32'h4);
      settle();
      chk("irqClear", 32'h0, irq);
      wr(6'h1D, 8'h00);
      fix <= 5'h00;
      settle();
      fix <= 5'h1F;
      settle();
      chk("irqMasked", 32'h0, irq);
      chk("pbPulses", 32'h3, pbPulses);
   endtask
   initial begin
      repeat (20) @(posedge ref_clk);
      resetn <= 1'h1;
      regDefaults();
      regAccess();
      routes();
      softReset();
      irqFlow();
      wrap_up();
   end
   initial begin
      repeat (3000) @(posedge ref_clk);
      n_fail++;
      wrap_up();
   end
endmodule // tb_wake_event_routing_masks
